//--- dmac_peer.sv
// Neighbour slice and fabric tile model driving the chain inputs
`timescale 1ns/1ps
`default_nettype none
module dmac_peer (
    input  wire logic casc_bit,
    input  wire logic tile_bit,
    input  wire logic sign_bit,
    output logic      cascade_carry_in,
    output logic      tile_carry_in,
    output logic      sign_ext_chain_in
);
    assign cascade_carry_in  = casc_bit;
    assign tile_carry_in     = tile_bit;
    assign sign_ext_chain_in = sign_bit;
endmodule
`default_nettype wire

//--- dmac_pkg.sv
// Shared constants and types for the low-half cascade MAC slice
package dmac_pkg;

    // Register offsets on the plain register port
    localparam logic [3:0] CFG_OFS = 4'h0;
    localparam logic [3:0] RES_OFS = 4'h4;
    localparam logic [3:0] FLG_OFS = 4'h8;

    // Configuration register field positions
    localparam int CFG_FN_LSB   = 0;
    localparam int CFG_CASC_BIT = 3;
    localparam int CFG_SEXT_BIT = 4;
    localparam int CFG_W        = 5;

    // Configuration value after reset: 32-bit accumulator, tile carry, no sign extension
    localparam logic [4:0] CFG_RESET = 5'h05;

    // Reset values of datapath state
    localparam logic [15:0] ACC_RESET = 16'h0000;
    localparam logic        FLAG_RESET = 1'b0;

    // Slice functions
    typedef enum logic [2:0] {
        FN_MUL8,
        FN_MUL16,
        FN_ADD16,
        FN_ADD32,
        FN_ACC16,
        FN_ACC32,
        FN_MAC8,
        FN_MAC16
    } dmac_fn_t;

endpackage

//--- dmac_slice.sv
// Low-half accumulator, cascade links and function modes of a MAC slice
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Low load select picks C, else adder
// - Low add/sub select: 0 add, 1 subtract
// - Cascade carry input feeds accumulator arithmetic
// - Tile carry input feeds the adder
// - Cascade carry output drives next slice
// - Tile carry output drives logic above
// - Sign extension input from previous slice
// - Sign extension output carries result sign
// - Eight multiplier, adder, accumulator, MAC functions
// - 8x8 product formed in upper half
// - Clock gate low holds the accumulator and flag registers
// - Output: full 32-bit or two halves
// - Low hold keeps low accumulator unchanged
// - Low clear zeroes low accumulator bits
module dmac_slice (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        slice_clock_gate,
    input  wire logic [15:0] a_operand,
    input  wire logic [15:0] b_operand,
    input  wire logic [15:0] c_operand,
    input  wire logic [15:0] d_operand,
    input  wire logic        low_acc_load_select,
    input  wire logic        low_addsub_select,
    input  wire logic        low_acc_hold,
    input  wire logic        low_acc_clear,
    input  wire logic        high_acc_load_select,
    input  wire logic        high_addsub_select,
    input  wire logic        high_acc_hold,
    input  wire logic        high_acc_clear,
    input  wire logic        cascade_carry_in,
    input  wire logic        tile_carry_in,
    input  wire logic        sign_ext_chain_in,
    output logic             cascade_carry_out,
    output logic             tile_carry_out,
    output logic             sign_ext_chain_out,
    output logic [31:0]      result,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata
);

    logic [4:0]  cfg_q;
    logic [15:0] acc_lo_q;
    logic [15:0] acc_hi_q;
    logic        cco_q;
    logic        tco_q;
    logic        sext_q;
    logic [31:0] rdata_q;

    // Function decode
    wire dmac_pkg::dmac_fn_t fn = dmac_pkg::dmac_fn_t'(cfg_q[dmac_pkg::CFG_FN_LSB +: 3]);
    wire casc_sel = cfg_q[dmac_pkg::CFG_CASC_BIT];
    wire sext_en  = cfg_q[dmac_pkg::CFG_SEXT_BIT];
    wire is_mul16 = (fn == dmac_pkg::FN_MUL16) || (fn == dmac_pkg::FN_MAC16);
    wire is_mul8  = (fn == dmac_pkg::FN_MUL8) || (fn == dmac_pkg::FN_MAC8);
    wire is_mul   = (fn == dmac_pkg::FN_MUL8) || (fn == dmac_pkg::FN_MUL16);
    wire is_add   = (fn == dmac_pkg::FN_ADD16) || (fn == dmac_pkg::FN_ADD32);
    wire is_accum = (fn == dmac_pkg::FN_ACC16) || (fn == dmac_pkg::FN_ACC32)
                 || (fn == dmac_pkg::FN_MAC8) || (fn == dmac_pkg::FN_MAC16);
    wire wide     = (fn == dmac_pkg::FN_MUL16) || (fn == dmac_pkg::FN_ADD32)
                 || (fn == dmac_pkg::FN_ACC32) || (fn == dmac_pkg::FN_MAC16);

    // Multipliers: one 16x16 or two 8x8
    wire [31:0] prod16  = 32'(a_operand) * 32'(b_operand);
    wire [15:0] prod_hi = 16'(a_operand[15:8]) * 16'(b_operand[15:8]);
    wire [15:0] prod_lo = 16'(a_operand[7:0]) * 16'(b_operand[7:0]);

    wire [15:0] p_hi_dir = (sext_en && wide) ? {16{sign_ext_chain_in}} : b_operand;

    wire [31:0] op_p = is_mul16 ? prod16
                     : is_mul8  ? {prod_hi, prod_lo}
                     : {p_hi_dir, a_operand};
    wire [31:0] op_q = is_accum ? {acc_hi_q, acc_lo_q}
                     : is_add   ? {d_operand, c_operand}
                     : 32'h0000_0000;

    // cascade or tile carry into low half
    wire cin_raw = is_mul ? 1'b0 : (casc_sel ? cascade_carry_in : tile_carry_in);

    wire        sub_lo  = low_addsub_select & ~is_mul;
    wire [15:0] pe_lo   = op_p[15:0] ^ {16{sub_lo}};
    // carry or borrow applied to adder
    wire [16:0] sum_lo  = {1'b0, op_q[15:0]} + {1'b0, pe_lo} + {16'h0000, cin_raw ^ sub_lo};

    // low carry feeds high half in wide modes
    // dual modes give high half no carry
    wire        sub_hi  = (wide ? low_addsub_select : high_addsub_select) & ~is_mul;
    wire        cin_hi  = wide ? sum_lo[16] : sub_hi;
    wire [15:0] pe_hi   = op_p[31:16] ^ {16{sub_hi}};
    wire [16:0] sum_hi  = {1'b0, op_q[31:16]} + {1'b0, pe_hi} + {16'h0000, cin_hi};

    wire co_hi    = sum_hi[16] ^ sub_hi;
    wire sign_hi  = op_q[31] ^ pe_hi[15] ^ sum_hi[16];

    // Next values of the accumulator halves
    // clear wins over hold and load
    // load C or take adder result
    wire [15:0] acc_lo_d = low_acc_clear ? dmac_pkg::ACC_RESET
                         : low_acc_hold  ? acc_lo_q
                         : low_acc_load_select ? c_operand
                         : sum_lo[15:0];
    wire [15:0] acc_hi_d = high_acc_clear ? dmac_pkg::ACC_RESET
                         : high_acc_hold  ? acc_hi_q
                         : high_acc_load_select ? c_operand
                         : sum_hi[15:0];

    // clock gate on all datapath registers
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_lo_q <= dmac_pkg::ACC_RESET;
            acc_hi_q <= dmac_pkg::ACC_RESET;
        end else if (slice_clock_gate) begin
            acc_lo_q <= acc_lo_d;
            acc_hi_q <= acc_hi_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cco_q  <= dmac_pkg::FLAG_RESET;
            tco_q  <= dmac_pkg::FLAG_RESET;
            sext_q <= dmac_pkg::FLAG_RESET;
        end else if (slice_clock_gate) begin
            cco_q  <= co_hi;
            tco_q  <= co_hi;
            sext_q <= sign_hi;
        end
    end

    // Register port decode
    wire cfg_hit = (reg_addr == dmac_pkg::CFG_OFS);
    wire res_hit = (reg_addr == dmac_pkg::RES_OFS);
    wire flg_hit = (reg_addr == dmac_pkg::FLG_OFS);
    wire [31:0] rd_mux = cfg_hit ? {27'h0, cfg_q}
                       : res_hit ? {acc_hi_q, acc_lo_q}
                       : flg_hit ? {29'h0, sext_q, tco_q, cco_q}
                       : 32'h0000_0000;

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_q <= dmac_pkg::CFG_RESET;
        end else if (reg_wr && cfg_hit) begin
            cfg_q <= reg_wdata[dmac_pkg::CFG_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    assign result             = {acc_hi_q, acc_lo_q};
    assign cascade_carry_out  = cco_q;
    assign tile_carry_out     = tco_q;
    assign sign_ext_chain_out = sext_q;
    assign reg_rdata          = rdata_q;

    // Checks
    wire lo_free = slice_clock_gate && !low_acc_clear && !low_acc_hold && !low_acc_load_select;
    wire hi_free = slice_clock_gate && !high_acc_clear && !high_acc_hold && !high_acc_load_select;

    lo_gate_a: assert property (@(posedge clk) disable iff (rst)
        !slice_clock_gate |=> $stable(result) && $stable(cascade_carry_out))
        else $error("Registers changed with clock gate low");

    lo_clear_a: assert property (@(posedge clk) disable iff (rst)
        slice_clock_gate && low_acc_clear |=> acc_lo_q == 16'h0000)
        else $error("Low clear did not zero low half");

    lo_hold_a: assert property (@(posedge clk) disable iff (rst)
        slice_clock_gate && !low_acc_clear && low_acc_hold |=> $stable(acc_lo_q))
        else $error("Low hold did not keep low half");

    lo_load_a: assert property (@(posedge clk) disable iff (rst)
        slice_clock_gate && !low_acc_clear && !low_acc_hold && low_acc_load_select
        |=> acc_lo_q == $past(c_operand))
        else $error("Low load did not take C");

    lo_add_a: assert property (@(posedge clk) disable iff (rst)
        lo_free && !reg_wr && fn == dmac_pkg::FN_ACC16 && !casc_sel && !low_addsub_select
        |=> acc_lo_q == 16'($past(acc_lo_q) + $past(a_operand) + 16'($past(tile_carry_in))))
        else $error("Low accumulate add wrong");

    lo_sub_a: assert property (@(posedge clk) disable iff (rst)
        lo_free && !reg_wr && fn == dmac_pkg::FN_ACC16 && !casc_sel && low_addsub_select
        |=> acc_lo_q == 16'($past(acc_lo_q) - $past(a_operand) - 16'($past(tile_carry_in))))
        else $error("Low accumulate subtract wrong");

    casc_in_a: assert property (@(posedge clk) disable iff (rst)
        lo_free && !reg_wr && fn == dmac_pkg::FN_ACC16 && casc_sel && !low_addsub_select
        |=> acc_lo_q == 16'($past(acc_lo_q) + $past(a_operand)
                           + 16'($past(cascade_carry_in))))
        else $error("Cascade carry not applied");

    wide_carry_a: assert property (@(posedge clk) disable iff (rst)
        lo_free && hi_free && !reg_wr && fn == dmac_pkg::FN_ACC32 && !casc_sel && !sext_en
        && !low_addsub_select
        |=> result == 32'($past(result) + {$past(b_operand), $past(a_operand)}
                          + 32'($past(tile_carry_in))))
        else $error("Wide accumulate carry wrong");

    dual_hi_a: assert property (@(posedge clk) disable iff (rst)
        hi_free && !reg_wr && fn == dmac_pkg::FN_ACC16 && !high_addsub_select
        |=> acc_hi_q == 16'($past(acc_hi_q) + $past(b_operand)))
        else $error("Dual high half took a carry");

    mul8_hi_a: assert property (@(posedge clk) disable iff (rst)
        hi_free && !reg_wr && fn == dmac_pkg::FN_MUL8
        |=> acc_hi_q == 16'($past(a_operand[15:8])) * 16'($past(b_operand[15:8])))
        else $error("Upper 8x8 product wrong");

    carry_out_a: assert property (@(posedge clk) disable iff (rst)
        slice_clock_gate |=> cascade_carry_out == $past(co_hi)
                             && tile_carry_out == cascade_carry_out)
        else $error("Carry outputs disagree");

    sign_out_a: assert property (@(posedge clk) disable iff (rst)
        slice_clock_gate && !high_addsub_select && !wide && !is_mul
        |=> sign_ext_chain_out == ($past(op_q[31]) ^ $past(op_p[31]) ^ $past(sum_hi[16])))
        else $error("Sign output wrong");

    wide_sub_a: assert property (@(posedge clk) disable iff (rst)
        lo_free && hi_free && fn == dmac_pkg::FN_ACC32 && !casc_sel && !sext_en
        && low_addsub_select
        |=> result == 32'($past(result) - {$past(b_operand), $past(a_operand)}
                          - 32'($past(tile_carry_in))))
        else $error("Wide accumulate borrow wrong");

    dual_sub_a: assert property (@(posedge clk) disable iff (rst)
        hi_free && fn == dmac_pkg::FN_ACC16 && high_addsub_select
        |=> acc_hi_q == 16'($past(acc_hi_q) - $past(b_operand)))
        else $error("Dual high half took a borrow");

    add_low_a: assert property (@(posedge clk) disable iff (rst)
        lo_free && fn == dmac_pkg::FN_ADD16 && !casc_sel && !low_addsub_select
        |=> acc_lo_q == 16'($past(c_operand) + $past(a_operand)
                            + 16'($past(tile_carry_in))))
        else $error("Low half adder result wrong");

    full_product_a: assert property (@(posedge clk) disable iff (rst)
        lo_free && hi_free && fn == dmac_pkg::FN_MUL16
        |=> result == 32'($past(a_operand)) * 32'($past(b_operand)))
        else $error("Full product wrong");

    low_product_a: assert property (@(posedge clk) disable iff (rst)
        lo_free && fn == dmac_pkg::FN_MUL8
        |=> acc_lo_q == 16'($past(a_operand[7:0])) * 16'($past(b_operand[7:0])))
        else $error("Lower 8x8 product wrong");

    mac_wide_a: assert property (@(posedge clk) disable iff (rst)
        lo_free && hi_free && fn == dmac_pkg::FN_MAC16 && !casc_sel && !low_addsub_select
        |=> result == 32'($past(result) + 32'($past(a_operand)) * 32'($past(b_operand))
                          + 32'($past(tile_carry_in))))
        else $error("Wide multiply-accumulate wrong");

    mac_high_a: assert property (@(posedge clk) disable iff (rst)
        hi_free && fn == dmac_pkg::FN_MAC8 && !high_addsub_select
        |=> acc_hi_q == 16'($past(acc_hi_q)
                            + 16'($past(a_operand[15:8])) * 16'($past(b_operand[15:8]))))
        else $error("Upper 8x8 accumulate wrong");

    sign_in_a: assert property (@(posedge clk) disable iff (rst)
        lo_free && hi_free && fn == dmac_pkg::FN_ADD32 && sext_en && !casc_sel
        && !low_addsub_select
        |=> result == 32'({$past(d_operand), $past(c_operand)}
                          + {{16{$past(sign_ext_chain_in)}}, $past(a_operand)}
                          + 32'($past(tile_carry_in))))
        else $error("Sign extension input not applied");

    casc_out_a: assert property (@(posedge clk) disable iff (rst)
        slice_clock_gate && fn == dmac_pkg::FN_ADD32 && !sext_en && !casc_sel
        && !low_addsub_select
        |=> cascade_carry_out == (33'({$past(d_operand), $past(c_operand)})
                                  + 33'({$past(b_operand), $past(a_operand)})
                                  + 33'($past(tile_carry_in)) >= 33'h100000000))
        else $error("Cascade carry output wrong");

    tile_out_a: assert property (@(posedge clk) disable iff (rst)
        slice_clock_gate && fn == dmac_pkg::FN_ADD16 && !high_addsub_select
        |=> tile_carry_out == (17'($past(d_operand)) + 17'($past(b_operand)) >= 17'h10000))
        else $error("Tile carry output wrong");

    sign_add_a: assert property (@(posedge clk) disable iff (rst)
        slice_clock_gate && fn == dmac_pkg::FN_ADD16 && !high_addsub_select
        |=> sign_ext_chain_out == (32'($signed($past(d_operand)))
                                   + 32'($signed($past(b_operand))) < 0))
        else $error("Sign output of dual add wrong");

    gate_flags_a: assert property (@(posedge clk) disable iff (rst)
        !slice_clock_gate |=> $stable(tile_carry_out) && $stable(sign_ext_chain_out))
        else $error("Flags changed with clock gate low");

endmodule

`default_nettype wire

//--- dmac_slice_tb_top.sv
// Self-checking bench for the low-half cascade MAC slice
`timescale 1ns/1ps
`default_nettype none
module dmac_slice_tb_top;
    logic        clk, rst, wr, rd, cci, tci, sxi, cco, tco, sxo, m_co, m_sx;
    logic [25:0] ctl;
    logic [3:0]  addr;
    logic [4:0]  m_cfg;
    logic [2:0]  fl;
    logic [31:0] ab, cd, wdata, res, rdata, rng, m_res;
    logic [31:0] q_res[$], q_rd[$];
    logic [2:0]  q_fl[$];
    int          q_due[$];
    int          err_total, n_compared, cyc;

    dmac_peer peer (.casc_bit(ctl[16]), .tile_bit(ctl[17]), .sign_bit(ctl[18]),
        .cascade_carry_in(cci), .tile_carry_in(tci), .sign_ext_chain_in(sxi));
    dmac_slice dut (.clk(clk), .rst(rst), .slice_clock_gate(~&ctl[2:0]),
        .a_operand(ab[15:0]), .b_operand(ab[31:16]), .c_operand(cd[15:0]),
        .d_operand(cd[31:16]), .low_acc_load_select(&ctl[4:3]), .low_addsub_select(ctl[5]),
        .low_acc_hold(&ctl[9:7]), .low_acc_clear(&ctl[13:10]),
        .high_acc_load_select(&ctl[15:14]), .high_addsub_select(ctl[6]),
        .high_acc_hold(&ctl[21:19]), .high_acc_clear(&ctl[25:22]),
        .cascade_carry_in(cci), .tile_carry_in(tci), .sign_ext_chain_in(sxi),
        .cascade_carry_out(cco), .tile_carry_out(tco), .sign_ext_chain_out(sxo),
        .result(res), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
        .reg_rdata(rdata));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    function automatic logic [17:0] half(input logic [15:0] q, p, input logic s, c);
        logic [16:0] u;
        logic [17:0] t;
        u = s ? {1'b0, q} - {1'b0, p} - c : {1'b0, q} + {1'b0, p} + c;
        t = s ? {{2{q[15]}}, q} - {{2{p[15]}}, p} - c : {{2{q[15]}}, q} + {{2{p[15]}}, p} + c;
        return {t[17], u[16], u[15:0]};
    endfunction

    function automatic logic [15:0] pick(input logic clr, hld, ld, input logic [15:0] o, cv, s);
        return clr ? 16'h0000 : hld ? o : ld ? cv : s;
    endfunction

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic stop_test();
        if (err_total == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic step(input logic w, r, input logic [3:0] ad, input logic [31:0] wd);
        logic [31:0] x, y, z, p, q;
        logic [17:0] lo, hi;
        logic [2:0]  fn;
        @(posedge clk);
        x = rnd();
        y = rnd();
        z = rnd();
        ctl <= x[25:0];
        ab <= y;
        cd <= z;
        wr <= w;
        rd <= r;
        addr <= ad;
        wdata <= wd;
        fn = m_cfg[2:0];
        if (fn == 3'h1 || fn == 3'h7) p = 32'(y[15:0]) * 32'(y[31:16]);
        else if (fn == 3'h0 || fn == 3'h6) p = {16'(y[15:8]) * 16'(y[31:24]),
                                                16'(y[7:0]) * 16'(y[23:16])};
        else p = {(m_cfg[4] && fn[0]) ? {16{x[18]}} : y[31:16], y[15:0]};
        q = fn[2] ? m_res : (fn[1] ? z : 32'h0);
        lo = half(q[15:0], p[15:0], fn[2:1] != 2'b00 && x[5],
            fn[2:1] != 2'b00 && (m_cfg[3] ? x[16] : x[17]));
        hi = half(q[31:16], p[31:16], fn[2:1] != 2'b00 && (fn[0] ? x[5] : x[6]), fn[0] && lo[16]);
        q_due.push_back(cyc + 2);
        q_rd.push_back(!r ? 32'h0 : ad == dmac_pkg::CFG_OFS ? {27'h0, m_cfg} :
            ad == dmac_pkg::RES_OFS ? m_res :
            ad == dmac_pkg::FLG_OFS ? {29'h0, m_sx, m_co, m_co} : 32'h0);
        if (!(&x[2:0])) begin
            m_res = {pick(&x[25:22], &x[21:19], &x[15:14], m_res[31:16], z[15:0], hi[15:0]),
                     pick(&x[13:10], &x[9:7], &x[4:3], m_res[15:0], z[15:0], lo[15:0])};
            m_co = hi[16];
            m_sx = hi[17];
        end
        if (w && ad == dmac_pkg::CFG_OFS) m_cfg = wd[4:0];
        q_res.push_back(m_res);
        q_fl.push_back({m_sx, m_co, m_co});
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            stop_test();
        end
    end

    always @(negedge clk) begin
        if (q_due.size() > 0 && q_due[0] == cyc) begin
            void'(q_due.pop_front());
            check("result", res, q_res.pop_front());
            fl = q_fl.pop_front();
            check("cascade carry", {31'h0, cco}, {31'h0, fl[0]});
            check("tile carry", {31'h0, tco}, {31'h0, fl[1]});
            check("sign out", {31'h0, sxo}, {31'h0, fl[2]});
            check("read data", rdata, q_rd.pop_front());
        end
    end

    initial begin
        rng = 32'h00000053;
        {ctl, ab, cd, wr, rd, addr, wdata} = '0;
        {m_res, m_co, m_sx} = '0;
        m_cfg = dmac_pkg::CFG_RESET;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        step(1'b0, 1'b1, dmac_pkg::CFG_OFS, 32'h0);
        // All functions, carry sources and sign extension
        for (int m = 0; m < 32; m++) begin
            step(1'b1, 1'b0, dmac_pkg::CFG_OFS, {27'h5a5a5a5, 5'(m)});
            step(1'b0, 1'b1, dmac_pkg::CFG_OFS, 32'h0);
            repeat (24) begin
                x_loop();
            end
        end
        repeat (3) @(posedge clk);
        stop_test();
    end

    task automatic x_loop();
        logic [31:0] r;
        r = rnd();
        step(r[0] & r[1], ~r[0] & r[1], r[1] ? r[5:2] : (r[5:2] | 4'h4), r);
    endtask
endmodule
`default_nettype wire
